//--- core/mcp_pkg.sv
// Operation
// - Commands act only on carriage return
// - Isolated plus-plus-plus enters config, reports status
// - Question mark dumps all register values
// - F loads factory defaults except ack mode and host rate, replies OK
// - H sends short command help text
// - P pings every second until input
// - Ping reply reports remote address, strength
// - Strength byte ranges 20 to E0 hex
// - Q exits silently; S saves, replies SAVED
// - R n = value CR writes register
// - Destination address 24 bits, default 7F7F7F
// - Own address 24 bits, transmit source
// - Channel code 0 to 4 selects channel
// - Power code three bits, minus 8 upward
// - RF rate code two bits, default 3
// - Host rate code three bits, eight rates
// - Acknowledge mode retries at most ten times
// - No RF traffic while configuring; the P command still raises ping_req in config mode
// - Serial 8N1, 19200 default, RTS/CTS
package mcp_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 40000000;
  localparam int CLK_NS = 25;
  localparam int PING_PERIOD_MS = 1000;
  localparam int PING_CYCLES = PING_PERIOD_MS * (CLK_HZ / 1000);
  localparam int ESC_GUARD_US = 1000;
  localparam int ESC_GUARD_CYCLES = (ESC_GUARD_US * 1000) / CLK_NS;
  localparam int ACK_MAX_RETRIES = 10;
  // ****************************************
  // Characters
  // ****************************************
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_QM = 8'h3f;
  localparam logic [7:0] CH_EQ = 8'h3d;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_LP = 8'h28;
  localparam logic [7:0] CH_RP = 8'h29;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_H = 8'h48;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_Q = 8'h51;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_S = 8'h53;
  // ****************************************
  // Register numbers, reset values, limits
  // ****************************************
  localparam logic [3:0] REG_DEST = 4'h1;
  localparam logic [3:0] REG_OWN = 4'h2;
  localparam logic [3:0] REG_CHAN = 4'h3;
  localparam logic [3:0] REG_POWER = 4'h4;
  localparam logic [3:0] REG_RFRATE = 4'h5;
  localparam logic [3:0] REG_ACK = 4'h6;
  localparam logic [3:0] REG_HOSTRATE = 4'h8;
  localparam logic [23:0] RST_ADDR = 24'h7f7f7f;
  localparam logic [2:0] RST_CHAN = 3'h2;
  localparam logic [2:0] RST_POWER = 3'h7;
  localparam logic [1:0] RST_RFRATE = 2'h3;
  localparam logic RST_ACK = 1'b0;
  localparam logic [2:0] RST_HOSTRATE = 3'h3;
  localparam logic [23:0] MAX_CHAN = 24'h000004;
  localparam logic [23:0] MAX_POWER = 24'h000007;
  localparam logic [23:0] MAX_RFRATE = 24'h000003;
  localparam logic [23:0] MAX_ACK = 24'h000001;
  localparam logic [23:0] MAX_HOSTRATE = 24'h000007;
  localparam logic [7:0] RSSI_MIN = 8'h20;
  localparam logic [7:0] RSSI_MAX = 8'he0;
  // ****************************************
  // Reply messages
  // ****************************************
  typedef enum logic [2:0] {
    MCP_MSG_STATUS = 3'h0,
    MCP_MSG_DUMP = 3'h1,
    MCP_MSG_OK = 3'h2,
    MCP_MSG_HELP = 3'h3,
    MCP_MSG_PING = 3'h4,
    MCP_MSG_SAVED = 3'h5,
    MCP_MSG_ERR = 3'h6
  } mcp_msg_t;
  localparam int MSG_LEN = 48;
  localparam logic [5:0] MSG_LAST = 6'd47;
endpackage

//--- core/mcp_parser.sv
`timescale 1ns/10ps
module mcp_parser
  import mcp_pkg::*;
#(
  parameter int PING_CYCLES_P = PING_CYCLES,
  parameter int ESC_GUARD_P = ESC_GUARD_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic tx_ready,
  input wire logic pong_valid,
  input wire logic [23:0] pong_addr,
  input wire logic [7:0] pong_rssi,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic config_mode,
  output logic ping_req,
  output logic save_req,
  output logic [23:0] destination_address,
  output logic [23:0] own_address,
  output logic [2:0] rf_channel_select,
  output logic [2:0] transmit_power_level,
  output logic [1:0] rf_rate_select,
  output logic acknowledge_enable,
  output logic [2:0] host_rate_select
);
  // ****************************************
  // Escape detection
  // ****************************************
  logic [31:0] idle_q;
  logic [1:0] plus_cnt_q;
  logic esc_armed_q;
  logic esc_hit;
  logic guard_ok;
  assign guard_ok = (idle_q >= 32'(ESC_GUARD_P));
  always_ff @(posedge clock) begin
    if (rst) begin
      idle_q <= '0;
      plus_cnt_q <= '0;
      esc_armed_q <= 1'b0;
    end else if (rx_valid) begin
      idle_q <= '0;
      esc_armed_q <= 1'b0;
      if (rx_data == CH_PLUS && (plus_cnt_q != 2'd0 || guard_ok)) begin
        plus_cnt_q <= plus_cnt_q + 2'd1;
        esc_armed_q <= (plus_cnt_q == 2'd2);
        if (plus_cnt_q == 2'd2) plus_cnt_q <= '0;
      end else begin
        plus_cnt_q <= '0;
      end
    end else if (idle_q != 32'hffffffff) begin
      idle_q <= idle_q + 32'd1;
    end
  end
  assign esc_hit = esc_armed_q && !config_mode && !rx_valid && guard_ok;

  // ****************************************
  // Command line collection
  // ****************************************
  logic [7:0] cmd_q;
  logic [3:0] regnum_q;
  logic [23:0] val_q;
  logic [3:0] pos_q;
  logic bad_q;
  logic [3:0] hex_v;
  logic hex_ok;
  logic line_done;
  always_comb begin
    hex_ok = 1'b1;
    hex_v = 4'h0;
    if (rx_data >= 8'h30 && rx_data <= 8'h39) hex_v = 4'(rx_data - 8'h30);
    else if (rx_data >= 8'h41 && rx_data <= 8'h46) hex_v = 4'(rx_data - 8'h37);
    else hex_ok = 1'b0;
  end
  assign line_done = config_mode && rx_valid && rx_data == CH_CR;
  always_ff @(posedge clock) begin
    if (rst || line_done || !config_mode) begin
      cmd_q <= '0;
      regnum_q <= '0;
      val_q <= '0;
      pos_q <= '0;
      bad_q <= 1'b0;
    end else if (rx_valid && rx_data != CH_LF) begin
      pos_q <= (pos_q == 4'hf) ? pos_q : pos_q + 4'd1;
      if (pos_q == 4'd0) cmd_q <= rx_data;
      else if (cmd_q != CH_R) bad_q <= 1'b1;
      else if (pos_q == 4'd1) begin
        regnum_q <= hex_v;
        bad_q <= bad_q | !hex_ok;
      end else if (pos_q == 4'd2) bad_q <= bad_q | (rx_data != CH_EQ);
      else if (pos_q > 4'd8 || !hex_ok) bad_q <= 1'b1;
      else val_q <= {val_q[19:0], hex_v};
    end
  end

  // ****************************************
  // Mode, ping and reply control
  // ****************************************
  typedef enum logic [1:0] {
    MCP_IDLE = 2'b00,
    MCP_SEND = 2'b01,
    MCP_PING = 2'b11
  } mcp_state_t;
  mcp_state_t state_q;
  mcp_msg_t msg_q;
  logic [5:0] idx_q;
  logic [31:0] ping_cnt_q;
  logic [23:0] pong_addr_q;
  logic [7:0] pong_rssi_q;
  logic wr_ok;
  logic [7:0] ch;
  logic ch_end;
  logic tx_load;
  // A byte moves into the output slot only when the slot is empty or being taken,
  // so a stalled host never sees the offered byte change under it
  assign tx_load = (state_q == MCP_SEND) && (!tx_valid || tx_ready);
  always_comb begin
    wr_ok = 1'b1;
    unique case (regnum_q)
      REG_DEST, REG_OWN: wr_ok = 1'b1;
      REG_CHAN: wr_ok = val_q <= MAX_CHAN;
      REG_POWER: wr_ok = val_q <= MAX_POWER;
      REG_RFRATE: wr_ok = val_q <= MAX_RFRATE;
      REG_ACK: wr_ok = val_q <= MAX_ACK;
      REG_HOSTRATE: wr_ok = val_q <= MAX_HOSTRATE;
      default: wr_ok = 1'b0;
    endcase
    wr_ok = wr_ok && !bad_q && pos_q >= 4'd4;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= MCP_IDLE;
      msg_q <= MCP_MSG_STATUS;
      idx_q <= '0;
      config_mode <= 1'b0;
      ping_cnt_q <= '0;
      ping_req <= 1'b0;
      save_req <= 1'b0;
      pong_addr_q <= '0;
      pong_rssi_q <= RSSI_MIN;
    end else begin
      ping_req <= 1'b0;
      save_req <= 1'b0;
      if (esc_hit) begin
        config_mode <= 1'b1;
        state_q <= MCP_SEND;
        msg_q <= MCP_MSG_STATUS;
        idx_q <= '0;
      end else if (state_q == MCP_PING && rx_valid) begin
        state_q <= MCP_IDLE;
      end else if (state_q == MCP_PING) begin
        ping_cnt_q <= ping_cnt_q + 32'd1;
        if (ping_cnt_q >= 32'(PING_CYCLES_P - 1)) begin
          ping_cnt_q <= '0;
          ping_req <= 1'b1;
        end
        if (pong_valid) begin
          pong_addr_q <= pong_addr;
          pong_rssi_q <= pong_rssi < RSSI_MIN ? RSSI_MIN :
                         (pong_rssi > RSSI_MAX ? RSSI_MAX : pong_rssi);
          state_q <= MCP_SEND;
          msg_q <= MCP_MSG_PING;
          idx_q <= '0;
        end
      end else if (state_q == MCP_SEND) begin
        if (tx_load) begin
          idx_q <= idx_q + 6'd1;
          if (ch_end) state_q <= (msg_q == MCP_MSG_PING) ? MCP_PING : MCP_IDLE;
        end
      end else if (line_done) begin
        idx_q <= '0;
        state_q <= MCP_SEND;
        unique case (cmd_q)
          CH_QM: msg_q <= MCP_MSG_DUMP;
          CH_F: msg_q <= MCP_MSG_OK;
          CH_H: msg_q <= MCP_MSG_HELP;
          CH_P: begin
            state_q <= MCP_PING;
            ping_req <= 1'b1;
            ping_cnt_q <= '0;
          end
          CH_S: begin
            msg_q <= MCP_MSG_SAVED;
            save_req <= 1'b1;
          end
          CH_Q: begin
            config_mode <= 1'b0;
            state_q <= MCP_IDLE;
          end
          CH_R: msg_q <= wr_ok ? MCP_MSG_OK : MCP_MSG_ERR;
          default: msg_q <= MCP_MSG_ERR;
        endcase
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      destination_address <= RST_ADDR;
      own_address <= RST_ADDR;
      rf_channel_select <= RST_CHAN;
      transmit_power_level <= RST_POWER;
      rf_rate_select <= RST_RFRATE;
      acknowledge_enable <= RST_ACK;
      host_rate_select <= RST_HOSTRATE;
    end else if (line_done && state_q == MCP_IDLE && cmd_q == CH_F) begin
      destination_address <= RST_ADDR;
      own_address <= RST_ADDR;
      rf_channel_select <= RST_CHAN;
      transmit_power_level <= RST_POWER;
      rf_rate_select <= RST_RFRATE;
    end else if (line_done && state_q == MCP_IDLE && cmd_q == CH_R && wr_ok) begin
      unique case (regnum_q)
        REG_DEST: destination_address <= val_q;
        REG_OWN: own_address <= val_q;
        REG_CHAN: rf_channel_select <= val_q[2:0];
        REG_POWER: transmit_power_level <= val_q[2:0];
        REG_RFRATE: rf_rate_select <= val_q[1:0];
        REG_ACK: acknowledge_enable <= val_q[0];
        REG_HOSTRATE: host_rate_select <= val_q[2:0];
        default: host_rate_select <= host_rate_select;
      endcase
    end
  end

  // ****************************************
  // Reply text generation
  // ****************************************
  function automatic logic [7:0] hexc(input logic [3:0] n);
    hexc = (n < 4'd10) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  logic [7:0] a_ch;
  logic [5:0] own_idx;
  always_comb begin
    a_ch = CH_SP;
    ch_end = 1'b0;
    ch = CH_SP;
    // Own address digits start at byte 7; sized here so the offset cannot go negative
    own_idx = idx_q - 6'd7;
    unique case (msg_q)
      MCP_MSG_STATUS: begin
        // "CONFIG\r\n"
        unique case (idx_q)
          6'd0: ch = 8'h43; 6'd1: ch = 8'h4f; 6'd2: ch = 8'h4e;
          6'd3: ch = 8'h46; 6'd4: ch = 8'h49; 6'd5: ch = 8'h47;
          6'd6: ch = CH_CR;
          default: begin ch = CH_LF; ch_end = 1'b1; end
        endcase
      end
      MCP_MSG_DUMP: begin
        // Dump: DDDDDD OOOOOO C P R A B
        if (idx_q < 6'd6) ch = hexc(destination_address[23 - 4 * idx_q[2:0] -: 4]);
        else if (idx_q == 6'd6 || idx_q == 6'd13 || idx_q == 6'd15 ||
                 idx_q == 6'd17 || idx_q == 6'd19 || idx_q == 6'd21) ch = CH_SP;
        else if (idx_q < 6'd13) ch = hexc(own_address[23 - 4 * own_idx[2:0] -: 4]);
        else if (idx_q == 6'd14) ch = hexc({1'b0, rf_channel_select});
        else if (idx_q == 6'd16) ch = hexc({1'b0, transmit_power_level});
        else if (idx_q == 6'd18) ch = hexc({2'b0, rf_rate_select});
        else if (idx_q == 6'd20) ch = hexc({3'b0, acknowledge_enable});
        else if (idx_q == 6'd22) ch = hexc({1'b0, host_rate_select});
        else if (idx_q == 6'd23) ch = CH_CR;
        else begin ch = CH_LF; ch_end = 1'b1; end
      end
      MCP_MSG_OK: begin
        unique case (idx_q)
          6'd0: ch = 8'h4f; 6'd1: ch = 8'h4b; 6'd2: ch = CH_CR;
          default: begin ch = CH_LF; ch_end = 1'b1; end
        endcase
      end
      MCP_MSG_SAVED: begin
        unique case (idx_q)
          6'd0: ch = CH_S; 6'd1: ch = 8'h41; 6'd2: ch = 8'h56;
          6'd3: ch = 8'h45; 6'd4: ch = 8'h44; 6'd5: ch = CH_CR;
          default: begin ch = CH_LF; ch_end = 1'b1; end
        endcase
      end
      MCP_MSG_HELP: begin
        unique case (idx_q)
          6'd0: ch = CH_QM; 6'd1: ch = CH_SP; 6'd2: ch = CH_F; 6'd3: ch = CH_SP;
          6'd4: ch = CH_H; 6'd5: ch = CH_SP; 6'd6: ch = CH_P; 6'd7: ch = CH_SP;
          6'd8: ch = CH_S; 6'd9: ch = CH_SP; 6'd10: ch = CH_Q; 6'd11: ch = CH_SP;
          6'd12: ch = CH_R; 6'd13: ch = 8'h6e; 6'd14: ch = CH_EQ; 6'd15: ch = 8'h78;
          6'd16: ch = CH_CR;
          default: begin ch = CH_LF; ch_end = 1'b1; end
        endcase
      end
      MCP_MSG_PING: begin
        if (idx_q < 6'd6) ch = hexc(pong_addr_q[23 - 4 * idx_q[2:0] -: 4]);
        else if (idx_q == 6'd6) ch = CH_SP;
        else if (idx_q == 6'd7) ch = CH_LP;
        else if (idx_q == 6'd8) ch = hexc(pong_rssi_q[7:4]);
        else if (idx_q == 6'd9) ch = hexc(pong_rssi_q[3:0]);
        else if (idx_q == 6'd10) ch = CH_RP;
        else if (idx_q == 6'd11) ch = CH_CR;
        else begin ch = CH_LF; ch_end = 1'b1; end
      end
      default: begin
        unique case (idx_q)
          6'd0: ch = CH_QM; 6'd1: ch = CH_CR;
          default: begin ch = CH_LF; ch_end = 1'b1; end
        endcase
      end
    endcase
    if (idx_q > MSG_LAST) ch_end = 1'b1;
    a_ch = ch;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_data <= '0;
      tx_valid <= 1'b0;
    end else if (tx_load) begin
      tx_valid <= 1'b1;
      tx_data <= a_ch;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end
endmodule // mcp_parser

//--- verif/mcp_parser_properties.sv
`timescale 1ns/10ps
module mcp_parser_properties
  import mcp_pkg::*;
#(
  parameter int ESC_GUARD_P = ESC_GUARD_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic tx_ready,
  input logic [7:0] tx_data,
  input logic tx_valid,
  input logic config_mode,
  input logic ping_req,
  input logic save_req,
  input logic [23:0] destination_address,
  input logic [23:0] own_address,
  input logic [2:0] rf_channel_select,
  input logic [2:0] transmit_power_level,
  input logic [1:0] rf_rate_select,
  input logic acknowledge_enable,
  input logic [2:0] host_rate_select
);
  // ****************************************
  // Helpers
  // ****************************************
  wire cr_in = rx_valid && rx_data == CH_CR;
  int quiet_q;
  always_ff @(posedge clock) begin
    if (rst || rx_valid) begin
      quiet_q <= 0;
    end else if (quiet_q < ESC_GUARD_P) begin
      quiet_q <= quiet_q + 1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_cr;
    cr_in;
  endsequence
  sequence s_other;
    rx_valid && !cr_in;
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  // reset defaults
  a_reset_defaults: assert property (disable iff (1'b0)
    rst |=> !tx_valid && !config_mode && destination_address == 24'h7f7f7f)
    else $error("reset state wrong");
  a_reply_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte dropped while stalled");
  a_chan_range: assert property (rf_channel_select <= 3'h4)
    else $error("channel code out of range");
  a_regs_need_cr: assert property (!cr_in && !$past(cr_in) |=>
    $stable({destination_address, own_address, rf_channel_select, transmit_power_level,
    rf_rate_select, acknowledge_enable, host_rate_select}))
    else $error("register changed without terminator");
  a_ping_in_config: assert property (ping_req |-> config_mode)
    else $error("ping outside configuration");
  a_ping_stops: assert property (s_other |=> !ping_req)
    else $error("ping after host byte");
  a_save_cause: assert property (save_req |-> config_mode && $past(cr_in))
    else $error("save without command");
  a_quit_on_cr: assert property ($fell(config_mode) |-> $past(cr_in))
    else $error("left configuration without command");
  a_escape_guard: assert property ($rose(config_mode) |-> quiet_q >= ESC_GUARD_P - 2)
    else $error("configuration entered without guard");
endmodule // mcp_parser_properties

bind mcp_parser mcp_parser_properties #(.ESC_GUARD_P(ESC_GUARD_P)) u_mcp_parser_properties (
  .clock, .rst, .rx_data, .rx_valid, .tx_ready, .tx_data, .tx_valid, .config_mode, .ping_req,
  .save_req, .destination_address, .own_address, .rf_channel_select, .transmit_power_level,
  .rf_rate_select, .acknowledge_enable, .host_rate_select);

//--- verif/mcp_host_model.sv
`timescale 1ns/10ps
module mcp_host_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic slow,
  output logic tx_ready
);
  // ****************************************
  // Host terminal receive side
  // ****************************************
  logic [7:0] got [$];
  logic ph_q;
  // flow control stalls
  // A slow host takes a byte every other cycle, so replies must wait
  always @(posedge clock) begin
    ph_q <= rst ? 1'b0 : ~ph_q;
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
  end
  assign tx_ready = !rst && (!slow || ph_q);
endmodule // mcp_host_model

//--- verif/mcp_parser_tb.sv
`timescale 1ns/10ps
module mcp_parser_tb;
  import mcp_pkg::*;
  localparam int ESC = 20;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] rx_data = 8'h00;
  logic rx_valid = 1'b0;
  logic pong_valid = 1'b0;
  logic [23:0] pong_addr = 24'h000000;
  logic [7:0] pong_rssi = 8'h00;
  logic slow = 1'b0;
  logic tx_ready, tx_valid, config_mode, ping_req, save_req, acknowledge_enable;
  logic [7:0] tx_data;
  logic [23:0] destination_address, own_address;
  logic [2:0] rf_channel_select, transmit_power_level, host_rate_select;
  logic [1:0] rf_rate_select;
  wire [59:0] regs = {destination_address, own_address, rf_channel_select,
    transmit_power_level, rf_rate_select, acknowledge_enable, host_rate_select};
  int n_errors = 0;
  int num_checks = 0;
  int n_ping = 0;
  int n_save = 0;
  int cycles = 0;
  int p0;
  // RF rate kept equal to host rate
  string wr [7] = '{"R1=987654", "R2=12", "R3=4", "R4=5", "R5=1", "R6=1", "R8=1"};
  string bad [6] = '{"R3=5", "R7=1", "R4=8", "R8=8", "R6=2", "r3=1"};
  always #12.5 clock = ~clock;
  mcp_parser #(.PING_CYCLES_P(100), .ESC_GUARD_P(ESC)) u_mcp_parser (.clock, .rst, .rx_data,
    .rx_valid, .tx_ready, .pong_valid, .pong_addr, .pong_rssi, .tx_data, .tx_valid,
    .config_mode, .ping_req, .save_req, .destination_address, .own_address,
    .rf_channel_select, .transmit_power_level, .rf_rate_select, .acknowledge_enable,
    .host_rate_select);
  mcp_host_model u_mcp_host_model (.clock, .rst, .tx_data, .tx_valid, .slow, .tx_ready);
  // ****************************************
  // Tasks
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] b);
    rx_data <= b;
    rx_valid <= 1'b1;
    @(posedge clock);
    rx_valid <= 1'b0;
    @(posedge clock);
  endtask
  task automatic put(input string s);
    for (int i = 0; i < s.len(); i++) send(s[i]);
  endtask
  task automatic expect_line(input string exp);
    repeat (4) @(posedge clock);
    while (tx_valid !== 1'b0) begin
      @(posedge clock);
    end
    check(u_mcp_host_model.got.size(), exp.len());
    for (int i = 0; i < exp.len(); i++) check(u_mcp_host_model.got[i], exp[i]);
    u_mcp_host_model.got.delete();
  endtask
  task automatic cmd(input string s, input string exp);
    u_mcp_host_model.got.delete();
    put(s);
    send(CH_CR);
    expect_line(exp);
  endtask
  task automatic pong(input logic [7:0] r);
    pong_addr <= 24'h123456;
    pong_rssi <= r;
    pong_valid <= 1'b1;
    @(posedge clock);
    pong_valid <= 1'b0;
    repeat (60) @(posedge clock);
  endtask
  // Hang guard, well above the thousand or so cycles the tests take
  always @(posedge clock) begin
    cycles <= cycles + 1;
    n_ping <= n_ping + int'(ping_req === 1'b1);
    n_save <= n_save + int'(save_req === 1'b1);
    if (cycles == 20000) begin
      n_errors++;
      $display("ERROR t=%0t timeout", $time);
      wrap_up();
    end
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check(regs, {24'h7f7f7f, 24'h7f7f7f, 3'h2, 3'h7, 2'h3, 1'h0, 3'h3});
    repeat (ESC + 5) @(posedge clock);
    put("A+++");
    repeat (ESC + 10) @(posedge clock);
    check(config_mode, 1'b0);
    u_mcp_host_model.got.delete();
    repeat (3) send(CH_PLUS);
    repeat (ESC + 10) @(posedge clock);
    expect_line("CONFIG\015\012");
    check(config_mode, 1'b1);
    $display("test escape done");
    foreach (wr[i]) cmd(wr[i], "OK\015\012");
    check(regs, {24'h987654, 24'h000012, 3'h4, 3'h5, 2'h1, 1'h1, 3'h1});
    foreach (bad[i]) cmd(bad[i], "?\015\012");
    check(regs, {24'h987654, 24'h000012, 3'h4, 3'h5, 2'h1, 1'h1, 3'h1});
    put("R3=1");
    repeat (10) @(posedge clock);
    check(rf_channel_select, 3'h4);
    cmd("", "OK\015\012");
    check(rf_channel_select, 3'h1);
    $display("test assign done");
    slow <= 1'b1;
    cmd("?", "987654 000012 1 5 1 1 1\015\012");
    cmd("H", "? F H P S Q Rn=x\015\012");
    slow <= 1'b0;
    cmd("S", "SAVED\015\012");
    check(n_save, 1);
    cmd("F", "OK\015\012");
    check(regs[59:4], {24'h7f7f7f, 24'h7f7f7f, 3'h2, 3'h7, 2'h3});
    $display("test replies done");
    p0 = n_ping;
    send(CH_P);
    send(CH_CR);
    pong(8'h05);
    pong(8'h55);
    repeat (130) @(posedge clock);
    send(CH_SP);
    repeat (300) @(posedge clock);
    check(n_ping - p0, 3);
    expect_line("123456 (20)\015\012123456 (55)\015\012");
    cmd("", "?\015\012");
    $display("test ping done");
    cmd("Q", "");
    check(config_mode, 1'b0);
    $display("test quit done");
    wrap_up();
  end
endmodule // mcp_parser_tb
